// *** serial_map.svh ***
// Purpose: offsets, field positions, reset values and counts of the
//          multiprocessor serial unit and its peer
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   definitions only
`ifndef SERIAL_MAP_SVH
`define SERIAL_MAP_SVH

// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_TX_HOLD 8'h08
`define OFF_RX_HOLD 8'h0C

// Control register fields
`define CB_TX_EN 0
`define CB_RX_EN 1
`define CB_TX_EMPTY_IE 2
`define CB_TX_DONE_IE 3
`define CB_RX_IE 4
`define CB_MP_FILTER 5
`define CB_MP_MODE 6
`define CB_PAR_EN 7
`define CB_PAR_ODD 8
`define CB_PORT_DIR 9
`define CB_PORT_DATA 10

// Status register fields
`define SB_TX_EMPTY 0
`define SB_TX_DONE 1
`define SB_RX_FULL 2
`define SB_OVERRUN 3
`define SB_FRAMING 4
`define SB_PARITY 5
`define SB_MP_SEND 6
`define SB_MP_RECV 7

// Reset values of the transmit flags
`define RST_TX_EMPTY 1'b1
`define RST_TX_DONE 1'b1

// Internal bit clock: system clocks per serial bit
`define SER_BIT_CYCLES 16

`endif

// *** serial_pkg.sv ***
// Purpose: shared types and frame helpers for both ends of the line
// Assumes: 8 data bits, one stop bit, optional ninth bit
// Notes:   ninth bit is parity or multiprocessor bit, never both
package serial_pkg;

  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_BUSY = 2'b10} tx_state_t;
  typedef enum logic [2:0]
  {
    RX_IDLE = 3'b001,
    RX_START = 3'b010,
    RX_BITS = 3'b100
  } rx_state_t;

  // Bits after the start bit: data, optional ninth bit, stop
  function automatic logic [3:0] frame_bits(input logic extra);
    frame_bits = extra ? 4'hA : 4'h9;
  endfunction

  // Whole frame, LSB first, start bit in bit 0, idle 1s on top
  function automatic logic [10:0] build_frame(input logic [7:0] data,
                                              input logic extra,
                                              input logic bit9);
    build_frame = extra ? {1'b1, bit9, data, 1'b0}
                        : {2'b11, data, 1'b0};
  endfunction

  // Parity bit for even (odd=0) or odd (odd=1) parity
  function automatic logic par_bit(input logic [7:0] data,
                                   input logic odd);
    par_bit = (^data) ^ odd;
  endfunction

endpackage

// *** serial_line_if.sv ***
// Purpose: serial line pair between the unit and a peer transceiver
// Assumes: unit's transmit pin may be released to general port logic
// Notes:   undriven line pulls up to mark
interface serial_line_if;
  logic dev_txd;
  logic dev_txd_oe;
  logic peer_txd;
  logic line_to_peer;
  logic line_to_dev;

  // Pull-up when the unit does not drive its pin
  assign line_to_peer = dev_txd_oe ? dev_txd : 1'b1;
  assign line_to_dev = peer_txd;

  modport device(output dev_txd, output dev_txd_oe, input line_to_dev);
  modport peer(output peer_txd, input line_to_peer);
endinterface

// *** serial_peer.sv ***
// Purpose: peer transceiver on the shared line, multiprocessor format
// Assumes: same clock and bit rate as the unit
// Notes:   hardware ID filter stands in for the receiving software
`include "serial_map.svh"
module serial_peer #(
  parameter int BIT_CYCLES = `SER_BIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  serial_line_if.peer line,
  input wire logic [7:0] own_id,
  input wire logic send_valid,
  input wire logic [7:0] send_data,
  input wire logic send_mp,
  output logic send_ready,
  output logic recv_valid,
  output logic [7:0] recv_data,
  output logic recv_error
);
  import serial_pkg::*;

  localparam logic [15:0] BIT_END = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF_END = 16'(BIT_CYCLES / 2 - 1);

  logic [10:0] tx_sh_r;
  logic [15:0] tx_cnt_r;
  logic [3:0] tx_idx_r;
  logic rxd_meta_r, rxd_s_r, rxd_prev_r;
  rx_state_t rx_state_r;
  logic [15:0] rx_cnt_r;
  logic [3:0] rx_idx_r;
  logic [8:0] rx_sh_r;
  logic selected_r;
  logic rx_end;

  // Transmit: always with multiprocessor bit, no parity
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      send_ready <= 1'b1;
      tx_sh_r <= 11'h7FF;
      tx_cnt_r <= 16'h0000;
      tx_idx_r <= 4'h0;
    end
    else if (send_ready && send_valid)
    begin
      send_ready <= 1'b0;
      tx_sh_r <= build_frame(send_data, 1'b1, send_mp);
      tx_cnt_r <= 16'h0000;
      tx_idx_r <= 4'h0;
    end
    else if (!send_ready)
    begin
      if (tx_cnt_r == BIT_END)
      begin
        tx_cnt_r <= 16'h0000;
        tx_sh_r <= {1'b1, tx_sh_r[10:1]};
        tx_idx_r <= tx_idx_r + 4'h1;
        if (tx_idx_r == frame_bits(1'b1))
          send_ready <= 1'b1;
      end
      else
        tx_cnt_r <= tx_cnt_r + 16'h0001;
    end
  end

  assign line.peer_txd = tx_sh_r[0];

  // Line input synchroniser and edge history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxd_meta_r <= 1'b1;
      rxd_s_r <= 1'b1;
      rxd_prev_r <= 1'b1;
    end
    else
    begin
      rxd_meta_r <= line.line_to_peer;
      rxd_s_r <= rxd_meta_r;
      rxd_prev_r <= rxd_s_r;
    end
  end

  assign rx_end = (rx_state_r == RX_BITS) && (rx_cnt_r == BIT_END) &&
                  (rx_idx_r == frame_bits(1'b1) - 4'h1);

  // Receive framing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state_r <= RX_IDLE;
      rx_cnt_r <= 16'h0000;
      rx_idx_r <= 4'h0;
      rx_sh_r <= 9'h000;
    end
    else
    begin
      case (rx_state_r)
        RX_IDLE:
          if (rxd_prev_r && !rxd_s_r)
          begin
            rx_state_r <= RX_START;
            rx_cnt_r <= 16'h0000;
          end
        RX_START:
          if (rx_cnt_r == HALF_END)
          begin
            rx_state_r <= rxd_s_r ? RX_IDLE : RX_BITS;
            rx_cnt_r <= 16'h0000;
            rx_idx_r <= 4'h0;
          end
          else
            rx_cnt_r <= rx_cnt_r + 16'h0001;
        RX_BITS:
          if (rx_cnt_r == BIT_END)
          begin
            rx_cnt_r <= 16'h0000;
            if (rx_idx_r < 4'h9)
              rx_sh_r[rx_idx_r] <= rxd_s_r;
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_end)
              rx_state_r <= RX_IDLE;
          end
          else
            rx_cnt_r <= rx_cnt_r + 16'h0001;
        default:
          rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // ID filter: ID frame selects or deselects, data passes when selected
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      selected_r <= 1'b0;
      recv_valid <= 1'b0;
      recv_data <= 8'h00;
      recv_error <= 1'b0;
    end
    else
    begin
      recv_valid <= 1'b0;
      if (rx_end)
      begin
        recv_error <= !rxd_s_r;
        if (rx_sh_r[8])
          selected_r <= (rx_sh_r[7:0] == own_id);
        else if (selected_r)
        begin
          recv_valid <= 1'b1;
          recv_data <= rx_sh_r[7:0];
        end
      end
    end
  end

endmodule

// *** async_serial_unit.sv ***
// What this block does
// - Holding register write clears buffer-empty flag
// - Empty flag 0: load shifter, set flag, send
// - At stop bit, pending word chains next frame
// - No word at stop: done flag, mark state
// - Software-chosen multiprocessor bit goes into frame
// - Multiprocessor bit 1 is ID, 0 data
// - Multiprocessor format ignores parity completely
// - Receiver software arms filter, re-arms on mismatch
// - Unmatched receiver skips data until next ID
// - Reading receive holding clears receive-full flag
// - Overrun or framing flag set halts reception
// - Six interrupt conditions on four request lines; the three errors share one
// - Transmit empty and done requests, each enabled
// - Empty and done flags read 1 after reset
// - Receive-full and receive-error requests
// - Writes always accepted; unsent word overwritten
// - Software writes once after seeing empty flag
// - Overrun keeps full flag, discards shifter
// - Simultaneous errors all flagged; full flag held
// - Break sets framing flag, reception halts, unless the armed ID filter skips it as data
// - Break: port direction 1, data 0, disable transmit
// - Transmit disable reinitialises, pin goes to port
//
// Purpose: asynchronous serial unit with multiprocessor format, APB regs
// Assumes: one clock pclk; bit rate fixed by BIT_CYCLES
// Notes:   APB answers with pready on the second access cycle
`include "serial_map.svh"
module async_serial_unit #(
  parameter int BIT_CYCLES = `SER_BIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tx_empty_irq,
  output logic tx_done_irq,
  output logic rx_full_irq,
  output logic rx_error_irq,
  serial_line_if.device line
);
  import serial_pkg::*;

  localparam logic [15:0] BIT_END = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF_END = 16'(BIT_CYCLES / 2 - 1);

  logic tx_enable_r, rx_enable_r, tx_empty_irq_enable_r;
  logic tx_done_irq_enable_r, rx_irq_enable_r, mp_id_filter_enable_r;
  logic mp_mode_r, par_en_r, par_odd_r;
  logic port_direction_reg_r, port_data_reg_r;
  logic tx_buffer_empty_flag_r, tx_done_flag_r, mp_bit_to_send_r;
  logic rx_full_flag_r, overrun_flag_r, framing_flag_r, parity_flag_r;
  logic rx_mp_r;
  logic [7:0] tx_holding_reg_r, rx_holding_reg_r;
  logic [31:0] rd_nxt;
  logic acc, wr, rd, mapped;
  tx_state_t tx_state_r;
  logic [10:0] tx_shift_reg_r;
  logic [15:0] tx_cnt_r;
  logic [3:0] tx_idx_r;
  logic extra, tx_last, tx_load;
  logic rxd_meta_r, rxd_s_r, rxd_prev_r;
  rx_state_t rx_state_r;
  logic [15:0] rx_cnt_r;
  logic [3:0] rx_idx_r;
  logic [8:0] rx_shift_reg_r;
  logic rx_end, framing_flag, parity_flag, skip, rx_take;

  // Ninth bit present for multiprocessor or parity format
  assign extra = mp_mode_r | par_en_r;

  // Bus decode; side effects only at the completing edge
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign rd = acc & !pwrite;
  assign mapped = (paddr == `OFF_CTRL) || (paddr == `OFF_STATUS) ||
                  (paddr == `OFF_TX_HOLD) || (paddr == `OFF_RX_HOLD);

  // Read data mux
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      `OFF_CTRL:
      begin
        rd_nxt[`CB_TX_EN] = tx_enable_r;
        rd_nxt[`CB_RX_EN] = rx_enable_r;
        rd_nxt[`CB_TX_EMPTY_IE] = tx_empty_irq_enable_r;
        rd_nxt[`CB_TX_DONE_IE] = tx_done_irq_enable_r;
        rd_nxt[`CB_RX_IE] = rx_irq_enable_r;
        rd_nxt[`CB_MP_FILTER] = mp_id_filter_enable_r;
        rd_nxt[`CB_MP_MODE] = mp_mode_r;
        rd_nxt[`CB_PAR_EN] = par_en_r;
        rd_nxt[`CB_PAR_ODD] = par_odd_r;
        rd_nxt[`CB_PORT_DIR] = port_direction_reg_r;
        rd_nxt[`CB_PORT_DATA] = port_data_reg_r;
      end
      `OFF_STATUS:
      begin
        rd_nxt[`SB_TX_EMPTY] = tx_buffer_empty_flag_r;
        rd_nxt[`SB_TX_DONE] = tx_done_flag_r;
        rd_nxt[`SB_RX_FULL] = rx_full_flag_r;
        rd_nxt[`SB_OVERRUN] = overrun_flag_r;
        rd_nxt[`SB_FRAMING] = framing_flag_r;
        rd_nxt[`SB_PARITY] = parity_flag_r;
        rd_nxt[`SB_MP_SEND] = mp_bit_to_send_r;
        rd_nxt[`SB_MP_RECV] = rx_mp_r;
      end
      `OFF_TX_HOLD: rd_nxt[7:0] = tx_holding_reg_r;
      `OFF_RX_HOLD: rd_nxt[7:0] = rx_holding_reg_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // APB answer: one wait state, error on unmapped offsets
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (psel && penable && !pready)
    begin
      pready <= 1'b1;
      pslverr <= !mapped;
      prdata <= rd_nxt;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Control register; a received ID frame clears the filter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {tx_enable_r, rx_enable_r, tx_empty_irq_enable_r} <= 3'h0;
      {tx_done_irq_enable_r, rx_irq_enable_r} <= 2'h0;
      {mp_id_filter_enable_r, mp_mode_r, par_en_r, par_odd_r} <= 4'h0;
      {port_direction_reg_r, port_data_reg_r} <= 2'h0;
    end
    else
    begin
      if (wr && paddr == `OFF_CTRL)
      begin
        tx_enable_r <= pwdata[`CB_TX_EN];
        rx_enable_r <= pwdata[`CB_RX_EN];
        tx_empty_irq_enable_r <= pwdata[`CB_TX_EMPTY_IE];
        tx_done_irq_enable_r <= pwdata[`CB_TX_DONE_IE];
        rx_irq_enable_r <= pwdata[`CB_RX_IE];
        mp_id_filter_enable_r <= pwdata[`CB_MP_FILTER];
        mp_mode_r <= pwdata[`CB_MP_MODE];
        par_en_r <= pwdata[`CB_PAR_EN];
        par_odd_r <= pwdata[`CB_PAR_ODD];
        port_direction_reg_r <= pwdata[`CB_PORT_DIR];
        port_data_reg_r <= pwdata[`CB_PORT_DATA];
      end
      if (rx_take && mp_mode_r && rx_shift_reg_r[8])
        mp_id_filter_enable_r <= 1'b0;
    end
  end

  // Transmit holding register and its flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_buffer_empty_flag_r <= `RST_TX_EMPTY;
      tx_done_flag_r <= `RST_TX_DONE;
      tx_holding_reg_r <= 8'h00;
      mp_bit_to_send_r <= 1'b0;
    end
    else
    begin
      if (wr && paddr == `OFF_STATUS)
        mp_bit_to_send_r <= pwdata[`SB_MP_SEND];
      if (wr && paddr == `OFF_TX_HOLD)
      begin
        tx_holding_reg_r <= pwdata[7:0];
        tx_buffer_empty_flag_r <= 1'b0;
      end
      else if (tx_load)
        tx_buffer_empty_flag_r <= 1'b1;
      if (tx_load)
        tx_done_flag_r <= 1'b0;
      else if (tx_state_r == TX_BUSY && tx_last)
        tx_done_flag_r <= 1'b1;
    end
  end

  // Load when idle, or chain at the end of the stop bit
  assign tx_last = (tx_cnt_r == BIT_END) &&
                   (tx_idx_r == frame_bits(extra));
  assign tx_load = tx_enable_r && !tx_buffer_empty_flag_r &&
                   (tx_state_r == TX_IDLE || tx_last);

  // Transmit shifter; disable reinitialises at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state_r <= TX_IDLE;
      tx_shift_reg_r <= 11'h7FF;
      tx_cnt_r <= 16'h0000;
      tx_idx_r <= 4'h0;
    end
    else if (!tx_enable_r)
    begin
      tx_state_r <= TX_IDLE;
      tx_shift_reg_r <= 11'h7FF;
      tx_cnt_r <= 16'h0000;
      tx_idx_r <= 4'h0;
    end
    else if (tx_load)
    begin
      tx_state_r <= TX_BUSY;
      tx_shift_reg_r <= build_frame(tx_holding_reg_r, extra,
        mp_mode_r ? mp_bit_to_send_r
                  : par_bit(tx_holding_reg_r, par_odd_r));
      tx_cnt_r <= 16'h0000;
      tx_idx_r <= 4'h0;
    end
    else
    begin
      case (tx_state_r)
        TX_IDLE: tx_shift_reg_r <= 11'h7FF;
        TX_BUSY:
          if (tx_last)
            tx_state_r <= TX_IDLE;
          else if (tx_cnt_r == BIT_END)
          begin
            tx_cnt_r <= 16'h0000;
            tx_idx_r <= tx_idx_r + 4'h1;
            tx_shift_reg_r <= {1'b1, tx_shift_reg_r[10:1]};
          end
          else
            tx_cnt_r <= tx_cnt_r + 16'h0001;
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end

  // Pin: shifter while enabled, else general port logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line.dev_txd <= 1'b1;
      line.dev_txd_oe <= 1'b0;
    end
    else
    begin
      line.dev_txd <= tx_enable_r ? tx_shift_reg_r[0]
                                  : port_data_reg_r;
      line.dev_txd_oe <= tx_enable_r | port_direction_reg_r;
    end
  end

  // Receive line synchroniser and edge history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxd_meta_r <= 1'b1;
      rxd_s_r <= 1'b1;
      rxd_prev_r <= 1'b1;
    end
    else
    begin
      rxd_meta_r <= line.line_to_dev;
      rxd_s_r <= rxd_meta_r;
      rxd_prev_r <= rxd_s_r;
    end
  end

  // Frame end decode; stop bit is the current sample
  assign rx_end = (rx_state_r == RX_BITS) && (rx_cnt_r == BIT_END) &&
                  (rx_idx_r == frame_bits(extra) - 4'h1);
  assign framing_flag = !rxd_s_r;
  assign parity_flag = par_en_r && !mp_mode_r &&
               (rx_shift_reg_r[8] !=
                par_bit(rx_shift_reg_r[7:0], par_odd_r));
  assign skip = mp_mode_r && mp_id_filter_enable_r &&
                !rx_shift_reg_r[8];
  assign rx_take = rx_end && !skip;

  // Receive framing; no new start while overrun or framing flag is set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state_r <= RX_IDLE;
      rx_cnt_r <= 16'h0000;
      rx_idx_r <= 4'h0;
      rx_shift_reg_r <= 9'h000;
    end
    else
    begin
      case (rx_state_r)
        RX_IDLE:
          if (rx_enable_r && !overrun_flag_r && !framing_flag_r &&
              rxd_prev_r && !rxd_s_r)
          begin
            rx_state_r <= RX_START;
            rx_cnt_r <= 16'h0000;
          end
        RX_START:
          if (rx_cnt_r == HALF_END)
          begin
            rx_state_r <= rxd_s_r ? RX_IDLE : RX_BITS;
            rx_cnt_r <= 16'h0000;
            rx_idx_r <= 4'h0;
          end
          else
            rx_cnt_r <= rx_cnt_r + 16'h0001;
        RX_BITS:
          if (rx_cnt_r == BIT_END)
          begin
            rx_cnt_r <= 16'h0000;
            if (rx_idx_r < 4'h9)
              rx_shift_reg_r[rx_idx_r] <= rxd_s_r;
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_end)
              rx_state_r <= RX_IDLE;
          end
          else
            rx_cnt_r <= rx_cnt_r + 16'h0001;
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // Receive holding and flags; hardware set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_holding_reg_r <= 8'h00;
      rx_mp_r <= 1'b0;
      {rx_full_flag_r, overrun_flag_r} <= 2'h0;
      {framing_flag_r, parity_flag_r} <= 2'h0;
    end
    else
    begin
      if (rd && paddr == `OFF_RX_HOLD)
        rx_full_flag_r <= 1'b0;
      if (wr && paddr == `OFF_STATUS)
      begin
        overrun_flag_r <= overrun_flag_r & pwdata[`SB_OVERRUN];
        framing_flag_r <= framing_flag_r & pwdata[`SB_FRAMING];
        parity_flag_r <= parity_flag_r & pwdata[`SB_PARITY];
      end
      if (rx_take)
      begin
        if (framing_flag)
          framing_flag_r <= 1'b1;
        if (parity_flag)
          parity_flag_r <= 1'b1;
        if (rx_full_flag_r)
        begin
          overrun_flag_r <= 1'b1;
          rx_full_flag_r <= 1'b1;
        end
        else
        begin
          rx_holding_reg_r <= rx_shift_reg_r[7:0];
          rx_mp_r <= rx_shift_reg_r[8];
          if (!framing_flag && !parity_flag)
            rx_full_flag_r <= 1'b1;
        end
      end
    end
  end

  // Interrupt requests, one shared line each, enable-gated
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {tx_empty_irq, tx_done_irq, rx_full_irq, rx_error_irq} <= 4'h0;
    end
    else
    begin
      tx_empty_irq <= tx_empty_irq_enable_r & tx_buffer_empty_flag_r;
      tx_done_irq <= tx_done_irq_enable_r & tx_done_flag_r;
      rx_full_irq <= rx_irq_enable_r & rx_full_flag_r;
      rx_error_irq <= rx_irq_enable_r &
        (overrun_flag_r | framing_flag_r | parity_flag_r);
    end
  end

endmodule

// *** serial_line_monitor.sv ***
// Purpose: framing checks on both directions of the serial line
// Assumes: every frame is 11 bits long (multiprocessor format)
// Notes: position counters start at a falling edge from idle
`include "serial_map.svh"
module serial_line_monitor #(
  parameter int BIT_CYCLES = `SER_BIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dev_txd,
  input wire logic dev_txd_oe,
  input wire logic peer_txd,
  input wire logic line_to_peer,
  input wire logic line_to_dev
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FRAME = 11 * BIT_CYCLES;
  localparam int STOP = 10 * BIT_CYCLES;
  logic [7:0] pos_p_r;
  logic [7:0] pos_d_r;

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Cycle position inside a frame sent by the unit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pos_p_r <= 8'h00;
    else if (pos_p_r != 8'h00)
      pos_p_r <= (pos_p_r == 8'(FRAME - 1)) ? 8'h00 : pos_p_r + 8'h01;
    else if (!line_to_peer)
      pos_p_r <= 8'h01;
  end

  // Cycle position inside a frame sent by the peer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pos_d_r <= 8'h00;
    else if (pos_d_r != 8'h00)
      pos_d_r <= (pos_d_r == 8'(FRAME - 1)) ? 8'h00 : pos_d_r + 8'h01;
    else if (!line_to_dev)
      pos_d_r <= 8'h01;
  end

  sequence s_edge_p;
    $changed(line_to_peer);
  endsequence
  sequence s_edge_d;
    $changed(line_to_dev);
  endsequence

  a_hold_unit: assert property (
    s_edge_p |=> $stable(line_to_peer)[*7])
    else $error("unit line changed inside a bit");
  a_start_unit: assert property (
    pos_p_r != 8'h00 && pos_p_r < 8'(BIT_CYCLES) |-> !line_to_peer)
    else $error("unit start bit not low");
  a_stop_unit: assert property (
    pos_p_r >= 8'(STOP) |-> line_to_peer)
    else $error("unit stop bit not high");
  a_drive_frame: assert property (
    pos_p_r != 8'h00 |-> dev_txd_oe && line_to_peer == dev_txd)
    else $error("unit pin released inside a frame");
  a_hold_peer: assert property (
    s_edge_d |=> $stable(line_to_dev)[*7])
    else $error("peer line changed inside a bit");
  a_start_peer: assert property (
    pos_d_r != 8'h00 && pos_d_r < 8'(BIT_CYCLES) |-> !line_to_dev)
    else $error("peer start bit not low");
  a_stop_peer: assert property (
    pos_d_r >= 8'(STOP) |-> line_to_dev)
    else $error("peer stop bit not high");
  a_reset_idle: assert property (
    $rose(presetn) |-> peer_txd && !dev_txd_oe)
    else $error("line not idle after reset");
endmodule

// *** tb.sv ***
// Purpose: drives the unit over APB and the peer's user side
// Assumes: BIT_CYCLES of 8, peer ID 3C, 11-bit frames
// Notes: waits follow the frame length
`include "serial_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BC = 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic tx_empty_irq, tx_done_irq, rx_full_irq, rx_error_irq;
  logic send_valid, send_mp, send_ready, recv_valid, recv_error;
  logic [7:0] paddr, send_data, recv_data;
  logic [31:0] pwdata, prdata, rd;
  int miscompares, checks_done, cycles, rx_count;

  serial_line_if line_if ();
  async_serial_unit #(.BIT_CYCLES(BC)) async_serial_unit_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_empty_irq(tx_empty_irq),
    .tx_done_irq(tx_done_irq), .rx_full_irq(rx_full_irq),
    .rx_error_irq(rx_error_irq), .line(line_if));
  serial_peer #(.BIT_CYCLES(BC)) serial_peer_inst (
    .pclk(pclk), .presetn(presetn), .line(line_if), .own_id(8'h3C),
    .send_valid(send_valid), .send_data(send_data), .send_mp(send_mp),
    .send_ready(send_ready), .recv_valid(recv_valid),
    .recv_data(recv_data), .recv_error(recv_error));
  serial_line_monitor #(.BIT_CYCLES(BC)) serial_line_monitor_inst (
    .pclk(pclk), .presetn(presetn), .dev_txd(line_if.dev_txd),
    .dev_txd_oe(line_if.dev_txd_oe), .peer_txd(line_if.peer_txd),
    .line_to_peer(line_if.line_to_peer), .line_to_dev(line_if.line_to_dev));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, got);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; read data and error kept in rd and err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Peer sends one frame; returns once it is on the line in full
  task automatic send(input logic [7:0] d, input logic mp);
    @(posedge pclk);
    send_valid <= 1'b1;
    send_data <= d;
    send_mp <= mp;
    @(posedge pclk);
    while (send_ready !== 1'b1)
      @(posedge pclk);
    send_valid <= 1'b0;
    tick(11 * BC + 8);
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Cycle ceiling and count of frames delivered to the peer
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (recv_valid === 1'b1)
      rx_count <= rx_count + 1;
    if (cycles == 5000)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH timeout expected 0 seen %0d", cycles);
      print_verdict();
    end
  end

  initial
  begin
    {presetn, psel, penable, pwrite, send_valid, send_mp} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    send_data = 8'h00;
    {miscompares, checks_done, cycles, rx_count} = 128'h0;
    tick(8);
    presetn <= 1'b1;
    // Reset state and unmapped access
    apb(1'b0, `OFF_STATUS, 32'h0);
    check("status", 32'h3, rd);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped", 32'h1, {rd[30:0], err});
    apb(1'b1, `OFF_CTRL, 32'h0C);
    tick(2);
    check("tx_irqs", 32'h3, {30'h0, tx_empty_irq, tx_done_irq});
    $display("test reset done");
    // ID, then two data words; the first one is overwritten
    apb(1'b1, `OFF_CTRL, 32'hDF);
    apb(1'b1, `OFF_STATUS, 32'h40);
    apb(1'b1, `OFF_TX_HOLD, 32'h3C);
    apb(1'b1, `OFF_STATUS, 32'h0);
    apb(1'b1, `OFF_TX_HOLD, 32'h11);
    apb(1'b0, `OFF_STATUS, 32'h0);
    check("pending", 32'h0, rd | {31'h0, tx_empty_irq});
    apb(1'b1, `OFF_TX_HOLD, 32'h22);
    tick(22 * BC);
    check("peer_data", 32'h22, {24'h0, recv_data});
    check("peer_count", 32'h1, rx_count);
    check("peer_err", 32'h0, {31'h0, recv_error});
    apb(1'b0, `OFF_STATUS, 32'h0);
    check("tx_done", 32'h3, rd);
    check("done_irq", 32'h1, {31'h0, tx_done_irq});
    // Wrong ID: the following data frame is skipped
    apb(1'b1, `OFF_STATUS, 32'h40);
    apb(1'b1, `OFF_TX_HOLD, 32'h55);
    apb(1'b1, `OFF_STATUS, 32'h0);
    apb(1'b1, `OFF_TX_HOLD, 32'h77);
    tick(22 * BC);
    check("skipped", 32'h1, rx_count);
    check("skip_data", 32'h22, {24'h0, recv_data});
    $display("test transmit done");
    // Filtered reception, overrun, halt and resume
    apb(1'b1, `OFF_CTRL, 32'hFF);
    send(8'h99, 1'b0);
    apb(1'b0, `OFF_STATUS, 32'h0);
    check("filtered", 32'h3, rd);
    send(8'h5A, 1'b1);
    apb(1'b0, `OFF_STATUS, 32'h0);
    check("id_taken", 32'h87, rd);
    apb(1'b0, `OFF_CTRL, 32'h0);
    check("filter_off", 32'hDF, rd);
    check("rx_irq", 32'h1, {31'h0, rx_full_irq});
    send(8'h66, 1'b0);
    apb(1'b0, `OFF_STATUS, 32'h0);
    check("overrun", 32'h0F, rd & 32'h3F);
    check("err_irq", 32'h1, {31'h0, rx_error_irq});
    apb(1'b0, `OFF_RX_HOLD, 32'h0);
    check("rx_hold", 32'h5A, rd);
    send(8'h77, 1'b0);
    apb(1'b0, `OFF_STATUS, 32'h0);
    check("halted", 32'h0B, rd & 32'h3F);
    apb(1'b1, `OFF_STATUS, 32'h0);
    send(8'h78, 1'b0);
    apb(1'b0, `OFF_RX_HOLD, 32'h0);
    check("resumed", 32'h78, rd);
    $display("test receive done");
    // Break from the port pin, then back to mark
    apb(1'b1, `OFF_CTRL, 32'h241);
    apb(1'b1, `OFF_CTRL, 32'h240);
    tick(2);
    check("break", 32'h0, {31'h0, line_if.line_to_peer});
    tick(3 * BC);
    apb(1'b1, `OFF_CTRL, 32'h640);
    tick(2);
    check("mark", 32'h1, {31'h0, line_if.line_to_peer});
    $display("test break done");
    tick(11 * BC);
    print_verdict();
  end
endmodule
